// ---- src/ebr_bus_ctrl.sv ----
`timescale 1ns/1ns

// Function
// RULE_01: At the sampling point, ready high adds a wait state, low ends cycle.
// RULE_02: Sampling point comes after programmed length plus memory wait states.
// RULE_03: Strobe leading edge is delayed or not by the read/write delay bit.
// RULE_04: External ready source may release ready on the strobe trailing edge.
// RULE_05: Unaligned asynchronous ready must stay low the minimum low time.
// RULE_06: Multiplexed mode appends an address-phase wait state after each cycle.
// RULE_07: Optional tristate wait state follows the cycle when enabled.
// RULE_08: A hold request waits until the running bus cycle is finished.
// RULE_09: After release the chip selects are floated, left to pull-ups.
// RULE_10: Own bus request rises no earlier than the step after the release.
// RULE_11: Regain starts only when hold returns high, not on own request.
// RULE_12: Outside master may return the bus without any request from us.
// RULE_13: Next own bus cycle starts only after regain has fully completed.
// RULE_14: Release: see hold, finish cycle, float, acknowledge; regain reverses.

module ebr_bus_ctrl
    import ebr_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic [3:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    input  wire logic [3:0]          byteenable,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    input  wire logic                link_clock,
    output logic                     bus_clock_output,
    input  wire logic                ready_n,
    input  wire logic                hold_n,
    output logic                     bus_grant_ack_out_n,
    output logic                     bus_regain_request_out_n,
    output logic                     read_select_strobe_n,
    output logic                     store_select_strobe_n,
    output logic      [CS_COUNT-1:0] chip_select_lines_n,
    output logic                     chip_select_oe_n,
    output logic                     bus_drive_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // System domain: Avalon slave and software-visible state.

    logic                ack_q;
    logic                wr_take;
    logic                rd_load;
    logic [31:0]         ctrl_q;
    logic [31:0]         wmask;
    logic                cmd_write_q;
    logic [CS_IDX_W-1:0] cmd_cs_q;
    logic                busy_q;
    logic                done_q;
    logic                launch;
    logic                done_sys;
    logic [RWAIT_W-1:0]  rwait_sys_q;
    logic [15:0]         count_q;
    logic [2:0]          link_stat_s;
    logic [31:0]         status_word;

    // One wait state on every access: the request is taken at the edge
    // where waitrequest is low, which keeps read data registered.
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_take     = write & ack_q;
    assign rd_load     = read & ~ack_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    assign wmask = CTRL_WMASK & {{8{byteenable[3]}}, {8{byteenable[2]}},
                                 {8{byteenable[1]}}, {8{byteenable[0]}}};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_take && address == CTRL_OFFSET) begin
            ctrl_q <= (ctrl_q & ~wmask) | (writedata & wmask);
        end
    end

    // A start while a cycle is still outstanding is dropped; software
    // sees busy in the status word.
    assign launch = wr_take && address == CMD_OFFSET && byteenable[0]
                    && writedata[CMD_START_BIT] && !busy_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmd_write_q <= 1'b0;
            cmd_cs_q    <= '0;
        end else if (launch) begin
            cmd_write_q <= writedata[CMD_WRITE_BIT];
            cmd_cs_q    <= writedata[CMD_CS_LSB +: CS_IDX_W];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (launch) begin
            busy_q <= 1'b1;
        end else if (done_sys) begin
            busy_q <= 1'b0;
        end
    end

    // The completion flag is cleared by writing one; a completion that
    // lands in the same cycle keeps it set.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else if (done_sys) begin
            done_q <= 1'b1;
        end else if (wr_take && address == STATUS_OFFSET && byteenable[0]
                     && writedata[STAT_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // The link holds its wait count from cycle end until the next start,
    // and no start can come before this capture, so the word is stable.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rwait_sys_q <= '0;
            count_q     <= COUNT_RESET;
        end else if (done_sys) begin
            rwait_sys_q <= rwait_q;
            count_q     <= count_q + 16'h0001;
        end
    end

    assign status_word = {16'h0000, rwait_sys_q, 3'b000,
                          link_stat_s[2], link_stat_s[1], link_stat_s[0],
                          done_q, busy_q};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            readdata <= '0;
        end else if (rd_load) begin
            case (address)
                CTRL_OFFSET:   readdata <= ctrl_q;
                CMD_OFFSET:    readdata <= {25'h0, cmd_cs_q, 2'b00,
                                            cmd_write_q, 1'b0};
                STATUS_OFFSET: readdata <= status_word;
                COUNT_OFFSET:  readdata <= {16'h0000, count_q};
                default:       readdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings between the two domains.

    logic             link_rst;
    logic [CFG_W-1:0] cfg_s;
    logic             cmd_link;
    logic             done_link;
    logic             hold_s;
    logic             ready_async_s;

    ebr_sync2 #(.W(1)) u_rst_sync (
        .clock (link_clock),
        .rst   (1'b0),
        .d     (sys_rst),
        .q     (link_rst)
    );

    // Configuration is quasi-static: change it only while no cycle runs.
    ebr_sync2 #(.W(CFG_W)) u_cfg_sync (
        .clock (link_clock),
        .rst   (link_rst),
        .d     ({ctrl_q[CTRL_WAIT_LSB +: WAIT_W], ctrl_q[5:0]}),
        .q     (cfg_s)
    );

    ebr_sync2 #(.W(2)) u_pin_sync (
        .clock (link_clock),
        .rst   (link_rst),
        .d     ({hold_n, ready_n}),
        .q     ({hold_s, ready_async_s})
    );

    ebr_sync2 #(.W(3)) u_stat_sync (
        .clock (clock),
        .rst   (sys_rst),
        .d     ({~bus_regain_request_out_n, ~hold_s,
                 ~bus_grant_ack_out_n}),
        .q     (link_stat_s)
    );

    ebr_pulse_xfer u_cmd_xfer (
        .src_clock (clock),
        .src_rst   (sys_rst),
        .src_pulse (launch),
        .dst_clock (link_clock),
        .dst_rst   (link_rst),
        .dst_pulse (cmd_link)
    );

    ebr_pulse_xfer u_done_xfer (
        .src_clock (link_clock),
        .src_rst   (link_rst),
        .src_pulse (done_link),
        .dst_clock (clock),
        .dst_rst   (sys_rst),
        .dst_pulse (done_sys)
    );

    ////////////////////////////////////////////////////////////////////////
    // Link domain: bus cycle and arbitration sequencer.

    logic               phase_q;
    logic               step;
    logic               ready_sync_q;
    logic               ready_low;
    logic               pend_q;
    logic               need_bus;
    ebr_state_t         state_q;
    ebr_state_t         state_d;
    logic [WAIT_W-1:0]  wcnt_q;
    logic [RWAIT_W-1:0] rwait_q;
    logic               cyc_write_q;
    logic [CS_IDX_W-1:0] cyc_cs_q;
    logic               cycle_end;

    // The exported bus clock is half the link clock; states advance once
    // per bus clock period.
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    assign bus_clock_output = phase_q;
    assign step             = phase_q;

    // Synchronous ready is aligned to the bus clock, so one stage is
    // enough and saves a period of latency over the asynchronous path.
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            ready_sync_q <= 1'b1;
        end else begin
            ready_sync_q <= ready_n;
        end
    end

    assign ready_low = cfg_s[CTRL_RDY_ASYNC_BIT] ? ~ready_async_s
                                                 : ~ready_sync_q;

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            pend_q <= 1'b0;
        end else if (cmd_link) begin
            pend_q <= 1'b1;
        end else if (step && state_q == EBR_IDLE && state_d == EBR_ADDR) begin
            pend_q <= 1'b0;
        end
    end

    assign need_bus  = pend_q | cfg_s[CTRL_REGAIN_BIT];
    assign cycle_end = state_q == EBR_STROBE && wcnt_q == '0 &&
                       (!cfg_s[CTRL_RDY_EN_BIT] || ready_low); // [RULE_01]

    always_comb begin
        state_d = state_q;
        case (state_q)
            EBR_IDLE: begin
                if (!hold_s) begin
                    state_d = EBR_FLOAT; // [RULE_08] [RULE_14]
                end else if (pend_q) begin
                    state_d = EBR_ADDR;
                end
            end
            EBR_ADDR: begin
                state_d = cfg_s[CTRL_RWDLY_BIT] ? EBR_DELAY
                                                : EBR_STROBE; // [RULE_03]
            end
            EBR_DELAY:  state_d = EBR_STROBE;
            EBR_STROBE: begin
                if (cycle_end) begin
                    if (cfg_s[CTRL_MUX_BIT]) begin
                        state_d = EBR_MUXW; // [RULE_06]
                    end else if (cfg_s[CTRL_TRI_BIT]) begin
                        state_d = EBR_TRI; // [RULE_07]
                    end else begin
                        state_d = EBR_IDLE;
                    end
                end
            end
            EBR_MUXW: begin
                state_d = cfg_s[CTRL_TRI_BIT] ? EBR_TRI
                                              : EBR_IDLE; // [RULE_07]
            end
            EBR_TRI:   state_d = EBR_IDLE;
            EBR_FLOAT: state_d = EBR_GRANT; // [RULE_14]
            EBR_GRANT: begin
                if (hold_s) begin
                    state_d = EBR_REGAIN; // [RULE_11] [RULE_12]
                end
            end
            EBR_REGAIN: state_d = EBR_IDLE; // [RULE_13] [RULE_14]
            default:    state_d = EBR_IDLE;
        endcase
    end

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            state_q <= EBR_IDLE;
        end else if (step) begin
            state_q <= state_d;
        end
    end

    // Memory wait states run first; the ready sampling point follows.
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            wcnt_q <= '0;
        end else if (step && state_q == EBR_ADDR) begin
            wcnt_q <= cfg_s[CFG_W-1 -: WAIT_W]; // [RULE_02]
        end else if (step && state_q == EBR_STROBE && wcnt_q != '0) begin
            wcnt_q <= wcnt_q - 4'h1; // [RULE_02]
        end
    end

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            rwait_q <= '0;
        end else if (step && state_q == EBR_ADDR) begin
            rwait_q <= '0;
        end else if (step && state_q == EBR_STROBE && wcnt_q == '0
                     && !cycle_end && rwait_q != 8'hff) begin
            rwait_q <= rwait_q + 8'h01; // [RULE_01]
        end
    end

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            cyc_write_q <= 1'b0;
            cyc_cs_q    <= '0;
        end else if (step && state_q == EBR_IDLE && state_d == EBR_ADDR) begin
            cyc_write_q <= cmd_write_q;
            cyc_cs_q    <= cmd_cs_q;
        end
    end

    assign done_link = step && cycle_end;

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, registered from the next state so they line up with it.

    logic in_cycle_d;
    logic strobe_d;
    logic floated_d;

    assign in_cycle_d = state_d == EBR_ADDR || state_d == EBR_DELAY ||
                        state_d == EBR_STROBE;
    assign strobe_d   = state_d == EBR_STROBE; // [RULE_03]
    assign floated_d  = state_d == EBR_FLOAT || state_d == EBR_GRANT ||
                        state_d == EBR_REGAIN;

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            read_select_strobe_n  <= 1'b1;
            store_select_strobe_n <= 1'b1;
            chip_select_lines_n   <= '1;
        end else if (step) begin
            // Strobe rises at cycle end, which lets the ready source let go.
            read_select_strobe_n  <= ~(strobe_d & ~cyc_write_q); // [RULE_04]
            store_select_strobe_n <= ~(strobe_d & cyc_write_q);
            for (int i = 0; i < CS_COUNT; i++) begin
                chip_select_lines_n[i] <=
                    ~(in_cycle_d && cyc_cs_q == i[CS_IDX_W-1:0]);
            end
        end
    end

    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            chip_select_oe_n         <= 1'b0;
            bus_drive_oe_n           <= 1'b0;
            bus_grant_ack_out_n      <= 1'b1;
            bus_regain_request_out_n <= 1'b1;
        end else if (step) begin
            chip_select_oe_n    <= floated_d; // [RULE_09] [RULE_14]
            bus_drive_oe_n      <= floated_d; // [RULE_14]
            bus_grant_ack_out_n <= ~(state_d == EBR_GRANT); // [RULE_14]
            bus_regain_request_out_n <= ~(state_q == EBR_GRANT &&
                state_d == EBR_GRANT && need_bus); // [RULE_10] [RULE_11]
        end
    end

endmodule : ebr_bus_ctrl

// ---- include/ebr_pkg.sv ----
package ebr_pkg;

    localparam int unsigned CS_COUNT    = 5;
    localparam int unsigned CS_IDX_W    = 3;
    localparam int unsigned WAIT_W      = 4;
    localparam int unsigned RWAIT_W     = 8;
    localparam int unsigned CFG_W       = 10;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
    localparam logic [3:0]  CMD_OFFSET    = 4'h4;
    localparam logic [3:0]  STATUS_OFFSET = 4'h8;
    localparam logic [3:0]  COUNT_OFFSET  = 4'hc;

    ////////////////////////////////////////////////////////////////////////
    localparam int unsigned CTRL_MUX_BIT      = 0;
    localparam int unsigned CTRL_RWDLY_BIT    = 1;
    localparam int unsigned CTRL_TRI_BIT      = 2;
    localparam int unsigned CTRL_RDY_EN_BIT   = 3;
    localparam int unsigned CTRL_RDY_ASYNC_BIT = 4;
    localparam int unsigned CTRL_REGAIN_BIT   = 5;
    localparam int unsigned CTRL_WAIT_LSB     = 8;
    localparam logic [31:0] CTRL_WMASK        = 32'h0000_0f3f;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0008;

    localparam int unsigned CMD_START_BIT     = 0;
    localparam int unsigned CMD_WRITE_BIT     = 1;
    localparam int unsigned CMD_CS_LSB        = 4;

    localparam int unsigned STAT_BUSY_BIT     = 0;
    localparam int unsigned STAT_DONE_BIT     = 1;
    localparam int unsigned STAT_GRANT_BIT    = 2;
    localparam int unsigned STAT_HOLD_BIT     = 3;
    localparam int unsigned STAT_BUS_REGAIN_REQUEST_OUT_BIT     = 4;
    localparam int unsigned STAT_RWAIT_LSB    = 8;

    localparam logic [15:0] COUNT_RESET       = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        EBR_IDLE,
        EBR_ADDR,
        EBR_DELAY,
        EBR_STROBE,
        EBR_MUXW,
        EBR_TRI,
        EBR_FLOAT,
        EBR_GRANT,
        EBR_REGAIN
    } ebr_state_t;

endpackage : ebr_pkg

// ---- src/ebr_sync2.sv ----
`timescale 1ns/1ns

module ebr_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // Each bit gets its own pair; the first stage feeds only the second.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (rst) begin
                meta_q[i] <= 1'b0;
                q[i]      <= 1'b0;
            end else begin
                meta_q[i] <= d[i];
                q[i]      <= meta_q[i];
            end
        end
    end

endmodule : ebr_sync2

// ---- src/ebr_pulse_xfer.sv ----
`timescale 1ns/1ns

module ebr_pulse_xfer (
    input  wire logic src_clock,
    input  wire logic src_rst,
    input  wire logic src_pulse,
    input  wire logic dst_clock,
    input  wire logic dst_rst,
    output logic      dst_pulse
);

    logic tgl_q;
    logic tgl_s;
    logic tgl_seen_q;

    // A toggle survives any ratio between the clocks, a bare pulse does not.
    always_ff @(posedge src_clock) begin
        if (src_rst) begin
            tgl_q <= 1'b0;
        end else if (src_pulse) begin
            tgl_q <= ~tgl_q;
        end
    end

    ebr_sync2 #(.W(1)) u_sync (
        .clock (dst_clock),
        .rst   (dst_rst),
        .d     (tgl_q),
        .q     (tgl_s)
    );

    always_ff @(posedge dst_clock) begin
        if (dst_rst) begin
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_s;
        end
    end

    assign dst_pulse = tgl_s ^ tgl_seen_q;

endmodule : ebr_pulse_xfer

// ---- tb/ebr_bus_ctrl_props.sv ----
`timescale 1ns/1ns
module ebr_bus_ctrl_props
    import ebr_pkg::*;
(
    input wire logic                clock,
    input wire logic                sys_rst,
    input wire logic                waitrequest,
    input wire logic                link_clock,
    input wire logic                bus_clock_output,
    input wire logic                hold_n,
    input wire logic                bus_grant_ack_out_n,
    input wire logic                bus_regain_request_out_n,
    input wire logic                read_select_strobe_n,
    input wire logic                store_select_strobe_n,
    input wire logic [CS_COUNT-1:0] chip_select_lines_n,
    input wire logic                chip_select_oe_n,
    input wire logic                bus_drive_oe_n
);
    // Link side leaves reset late; its checks wait longer.
    logic [2:0] lrst_q = 3'h7;
    wire        lr   = sys_rst | (|lrst_q);
    wire        strb = !(read_select_strobe_n && store_select_strobe_n);
    always_ff @(posedge link_clock) begin
        lrst_q <= {lrst_q[1:0], sys_rst};
    end
    ////////////////////////////////////////
    sequence s_float;
        bus_drive_oe_n && chip_select_oe_n;
    endsequence
    property p_float_ack;
        @(posedge link_clock) disable iff (lr)
        $fell(bus_grant_ack_out_n) |-> s_float ##0 $past(chip_select_oe_n, 2);
    endproperty
    a_float_ack: assert property (p_float_ack)
        else $error("early ack");
    property p_grant_float;
        @(posedge link_clock) disable iff (lr)
        !bus_grant_ack_out_n |-> s_float;
    endproperty
    a_grant_float: assert property (p_grant_float)
        else $error("cs driven");
    property p_req;
        @(posedge link_clock) disable iff (lr)
        $fell(bus_regain_request_out_n) |->
            !bus_grant_ack_out_n && !$past(bus_grant_ack_out_n, 2);
    endproperty
    a_req: assert property (p_req)
        else $error("early req");
    property p_strobe_driven;
        @(posedge link_clock) disable iff (lr)
        strb |-> !bus_drive_oe_n && !chip_select_oe_n && bus_grant_ack_out_n;
    endproperty
    a_strobe_driven: assert property (p_strobe_driven)
        else $error("not owned");
    property p_finish;
        @(posedge link_clock) disable iff (lr)
        $rose(bus_drive_oe_n) |-> $past(!strb);
    endproperty
    a_finish: assert property (p_finish)
        else $error("mid float");
    property p_regain;
        @(posedge link_clock) disable iff (lr)
        $rose(bus_grant_ack_out_n) |-> s_float ##[1:4] !bus_drive_oe_n;
    endproperty
    a_regain: assert property (p_regain)
        else $error("regain order");
    property p_regain_hold;
        @(posedge link_clock) disable iff (lr)
        $rose(bus_grant_ack_out_n) |-> $past(hold_n, 2);
    endproperty
    a_regain_hold: assert property (p_regain_hold)
        else $error("regain no hold");
    property p_one_sel;
        @(posedge link_clock) disable iff (lr)
        strb |-> (read_select_strobe_n ^ store_select_strobe_n)
            && $onehot(~chip_select_lines_n);
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("not unique");
    property p_step;
        @(posedge link_clock) disable iff (lr)
        $changed(read_select_strobe_n) || $changed(store_select_strobe_n)
            |-> $past(bus_clock_output);
    endproperty
    a_step: assert property (p_step)
        else $error("off step");
    property p_bus_clk;
        @(posedge link_clock) disable iff (lr)
        bus_clock_output != $past(bus_clock_output);
    endproperty
    a_bus_clk: assert property (p_bus_clk)
        else $error("clk stall");
    property p_wait;
        @(posedge clock) disable iff (sys_rst)
        waitrequest |=> !waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait long");
endmodule : ebr_bus_ctrl_props

bind ebr_bus_ctrl ebr_bus_ctrl_props u_props (.*);

// ---- tb/ebr_far_side.sv ----
`timescale 1ns/1ns
module ebr_far_side
    import ebr_pkg::*;
(
    input wire logic                link_clock,
    input wire logic                bus_clock_output,
    input wire logic                rd_n,
    input wire logic                wr_n,
    input wire logic [CS_COUNT-1:0] cs_drive_n,
    input wire logic                cs_oe_n,
    input wire logic [3:0]          ready_lat,
    input wire logic                hold_req,
    output logic                    ready_n = 1'b1,
    output logic                    hold_n = 1'b1,
    output logic [CS_COUNT-1:0]     cs_level
);
    logic [3:0] step_q = 4'h0;
    logic [3:0] low_q = 4'h0;
    assign cs_level = cs_oe_n ? '1 : cs_drive_n;
    always_ff @(posedge link_clock) begin
        hold_n <= !hold_req;
    end
    // Five link edges low cover the async minimum.
    always_ff @(posedge link_clock) begin
        if (!(rd_n && wr_n)) begin
            if (bus_clock_output && step_q != 4'hf) begin
                step_q <= step_q + 4'h1;
            end
            if (step_q >= ready_lat) begin
                ready_n <= 1'b0;
            end
        end else if (ready_n || low_q >= 4'h5) begin
            ready_n <= 1'b1;
            step_q <= 4'h0;
        end
        low_q <= ready_n ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
    end
endmodule : ebr_far_side

// ---- tb/ext_bus_ready_and_hold_arbitration_tb.sv ----
`timescale 1ns/1ns
module ext_bus_ready_and_hold_arbitration_tb
    import ebr_pkg::*;
;
    logic clock, sys_rst, read, write, waitrequest, link_clock, bco;
    logic ready_n, hold_n, ack_n, req_n, rs_n, ws_n, cs_oe_n, bus_oe_n;
    logic hold_req, st_rd;
    logic [3:0] address, byteenable, ready_lat;
    logic [31:0] writedata, readdata, q, rnd;
    logic [4:0] cs_n, cs_lvl, cs_q, st_cs;
    int n_errors = 0, samples_checked = 0, lk = 0, t_cs, t_st, st_len;
    int expc = 0;
    logic strb_q = 1'b0;
    ebr_bus_ctrl dut (.*, .bus_clock_output(bco),
        .bus_grant_ack_out_n(ack_n), .bus_regain_request_out_n(req_n),
        .read_select_strobe_n(rs_n), .store_select_strobe_n(ws_n),
        .chip_select_lines_n(cs_n), .chip_select_oe_n(cs_oe_n),
        .bus_drive_oe_n(bus_oe_n));
    ebr_far_side far (.*, .bus_clock_output(bco), .rd_n(rs_n), .wr_n(ws_n),
        .cs_drive_n(cs_n), .cs_level(cs_lvl));
    ////////////////////////////////////////
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    initial begin
        link_clock = 0;
        #3;
        forever begin
            #7 link_clock = 1;
            #8 link_clock = 0;
        end
    end
    always @(posedge link_clock) begin
        lk++;
        if (cs_lvl != 5'h1f && cs_q == 5'h1f) t_cs = lk;
        if (!(rs_n && ws_n) && !strb_q) begin
            t_st = lk;
            st_rd = !rs_n;
            st_cs = cs_lvl;
        end
        if (rs_n && ws_n && strb_q) st_len = lk - t_st;
        strb_q = !(rs_n && ws_n);
        cs_q = cs_lvl;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do @(posedge clock); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : av
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do av(0, STATUS_OFFSET, 0, q); while (q[b] !== v && n++ < 300);
        chk(q[b], v);
    endtask : poll
    task automatic cmd(input logic [2:0] cs, input logic wr);
        av(1, CMD_OFFSET, {25'h0, cs, 2'b0, wr, 1'b1}, q);
    endtask : cmd
    task automatic count_done();
        expc++;
        av(1, STATUS_OFFSET, 32'h2, q);
        av(0, COUNT_OFFSET, 0, q);
        chk(q, 32'(expc[15:0]));
    endtask : count_done
    ////////////////////////////////////////
    initial begin
        sys_rst = 1; read = 0; write = 0; address = 0; writedata = 0;
        byteenable = 4'hf; hold_req = 0; ready_lat = 0; rnd = 32'h88392ae5;
        repeat (5) @(posedge clock);
        sys_rst <= 0;
        av(0, CTRL_OFFSET, 0, q); chk(q, CTRL_RESET);
        av(0, COUNT_OFFSET, 0, q); chk(q, {16'h0, COUNT_RESET});
        av(1, 4'h2, 32'hffffffff, q);
        av(0, 4'h2, 0, q); chk(q, 32'h0);
        av(1, CTRL_OFFSET, 32'hffffffff, q);
        av(0, CTRL_OFFSET, 0, q); chk(q, CTRL_WMASK);
        for (int i = 0; i < 14; i++) begin
            rnd = lfsr(rnd);
            if (i < 2) rnd = i ? '1 : '0;
            @(posedge clock);
            ready_lat <= {2'b0, rnd[13:12]};
            av(1, CTRL_OFFSET, {20'h0, rnd[11:8], 3'h0, rnd[4], 1'b1,
                rnd[2:0]}, q);
            cmd(3'(rnd[18:16] % 3'd5), rnd[20]);
            poll(STAT_DONE_BIT, 1'b1);
            chk(32'(t_st - t_cs), rnd[1] ? 32'h4 : 32'h2);
            chk(st_len >= 2 * (rnd[11:8] + 1), 32'h1);
            chk(st_len >= 2 * rnd[13:12], 32'h1);
            chk(st_cs, {27'h0, ~(5'h1 << (rnd[18:16] % 3'd5))});
            chk(st_rd, !rnd[20]);
            count_done();
        end
        cmd(3'h1, 1'b0);
        wait (!rs_n);
        @(posedge clock);
        hold_req <= 1'b1;
        poll(STAT_GRANT_BIT, 1'b1);
        av(0, COUNT_OFFSET, 0, q); chk(q, 32'(expc + 1));
        count_done();
        chk(cs_lvl, 32'h1f);
        chk(req_n, 32'h1);
        cmd(3'h4, 1'b1);
        poll(STAT_BUS_REGAIN_REQUEST_OUT_BIT, 1'b1);
        chk(req_n, 32'h0);
        av(0, COUNT_OFFSET, 0, q); chk(q, 32'(expc));
        hold_req <= 1'b0;
        poll(STAT_DONE_BIT, 1'b1);
        chk(st_cs, 32'h0f);
        count_done();
        hold_req <= 1'b1;
        poll(STAT_GRANT_BIT, 1'b1);
        chk(req_n, 32'h1);
        hold_req <= 1'b0;
        poll(STAT_GRANT_BIT, 1'b0);
        cmd(3'h0, 1'b0);
        poll(STAT_DONE_BIT, 1'b1);
        count_done();
        print_verdict();
    end
    // Span: longest cycle mix plus a wide margin.
    initial begin
        #1900000;
        n_errors++;
        print_verdict();
    end
endmodule : ext_bus_ready_and_hold_arbitration_tb
